// file: sdqw_pkg.sv
// Shared constants and types for the multi-line serial write decoder and its host end
package sdqw_pkg;
	// Command codes, always shifted in on line 0, most significant bit first
	localparam logic [7:0] SDQW_OPC_DUAL = 8'hB2;
	localparam logic [7:0] SDQW_OPC_QUAD = 8'hE2;
	localparam logic [5:0] SDQW_OPC_BITS = 6'h08;
	localparam logic [5:0] SDQW_ADDR_BITS = 6'h10;
	localparam logic [5:0] SDQW_WORD_BITS = 6'h20;
	localparam logic [5:0] SDQW_STEP_ONE = 6'h01;
	localparam logic [5:0] SDQW_STEP_DUAL = 6'h02;
	localparam logic [5:0] SDQW_STEP_QUAD = 6'h04;
	localparam logic [15:0] SDQW_ADDR_STRIDE = 16'h0004;
	// Link timing, in ns, and the core clock period
	localparam real SDQW_CORE_PERIOD_NS = 8.0;
	localparam real SDQW_SCLK_MIN_PERIOD_NS = 12.5;
	localparam real SDQW_CS_IDLE_MIN_NS = 50.0;
	// Least times round up to whole core cycles
	localparam int SDQW_SCLK_HALF_MIN_CYC =
		(SDQW_SCLK_MIN_PERIOD_NS / 2.0 / SDQW_CORE_PERIOD_NS) > 1.0 ?
		int'($ceil(SDQW_SCLK_MIN_PERIOD_NS / 2.0 / SDQW_CORE_PERIOD_NS)) : 1;
	localparam int SDQW_CS_IDLE_CYC = int'($ceil(SDQW_CS_IDLE_MIN_NS / SDQW_CORE_PERIOD_NS));

	// Device decoder states, Gray along idle, opcode, address, data
	typedef enum logic [2:0]
	{
		SDQW_D_IDLE = 3'h0,
		SDQW_D_OPC = 3'h1,
		SDQW_D_ADDR = 3'h3,
		SDQW_D_DATA = 3'h2,
		SDQW_D_SKIP = 3'h6
	} sdqw_dev_state_t;

	// Host sequencer states
	typedef enum logic [2:0]
	{
		SDQW_H_IDLE = 3'h0,
		SDQW_H_SEL = 3'h1,
		SDQW_H_SHIFT = 3'h3,
		SDQW_H_LOAD = 3'h2,
		SDQW_H_GAP = 3'h6
	} sdqw_host_state_t;

	typedef enum logic [1:0]
	{
		SDQW_U_OPC = 2'h0,
		SDQW_U_ADDR = 2'h1,
		SDQW_U_DATA = 2'h3
	} sdqw_unit_t;
endpackage

// file: sdqw_link_if.sv
// Serial link between the host end and the device end, with wire resolution
`timescale 1ns/100ps
`default_nettype none
interface sdqw_link_if;
	logic target_select_n;
	logic sclk;
	logic [3:0] host_io_o;
	logic [3:0] host_io_oe;
	logic [3:0] dev_io_o;
	logic [3:0] dev_io_oe;
	logic [3:0] serial_io_lines;

	// Undriven lines read high, as with a weak pull-up
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (host_io_oe[i])
				serial_io_lines[i] = host_io_o[i];
			else if (dev_io_oe[i])
				serial_io_lines[i] = dev_io_o[i];
			else
				serial_io_lines[i] = 1'b1;
		end
	end

	modport host
	(
		output target_select_n,
		output sclk,
		output host_io_o,
		output host_io_oe,
		input serial_io_lines
	);
	modport device
	(
		input target_select_n,
		input sclk,
		input serial_io_lines,
		output dev_io_o,
		output dev_io_oe
	);
endinterface
`default_nettype wire

// file: sdqw_device.sv
// Device end: decodes dual and quad address/data writes and commits whole words
`timescale 1ns/100ps
`default_nettype none
module sdqw_device
	import sdqw_pkg::*;
#(
	parameter int ADDR_W = 16, // Byte address width
	parameter int DATA_W = 32 // Register word width
)
(
	input wire logic core_clk, // Core clock, 125 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	sdqw_link_if.device link, // Serial link pins
	input wire logic quad_serial_protocol_mode, // High while in quad-serial protocol
	output logic wr_valid, // One-cycle pulse: register write
	output logic [ADDR_W-1:0] wr_addr, // Byte address of the write
	output logic [DATA_W-1:0] wr_data, // Word to write
	output logic cmd_reject, // One-cycle pulse: opcode not accepted
	output logic word_dropped, // One-cycle pulse: partial word discarded
	output logic busy // Level: a write command is in progress
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Bit 5 target select, bit 4 serial clock, bits 3:0 the io lines
	logic [5:0] pin_s1_r;
	logic [5:0] pin_s2_r;
	logic [5:0] pin_s3_r;
	logic [5:0] pin_f_r;
	logic sclk_prev_r;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			// Reset to the idle pin levels: select high, clock low, lines pulled up
			pin_s1_r <= 6'h2F;
			pin_s2_r <= 6'h2F;
			pin_s3_r <= 6'h2F;
			pin_f_r <= 6'h2F;
			sclk_prev_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= {link.target_select_n, link.sclk, link.serial_io_lines};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			// A bit changes only once the second and third stages agree
			pin_f_r <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
			sclk_prev_r <= pin_f_r[4];
		end
	end

	logic cs_n;
	logic sclk_rise;
	logic [3:0] io_in;

	assign cs_n = pin_f_r[5];
	assign sclk_rise = pin_f_r[4] & ~sclk_prev_r;
	// Io lines pass the same chain as the clock, so they stay aligned to its edge
	assign io_in = pin_f_r[3:0];

	// The device never drives the io lines during writes
	assign link.dev_io_o = 4'h0;
	assign link.dev_io_oe = 4'h0;

	// ----------------------------------------------------------------
	// Shift path
	// ----------------------------------------------------------------
	sdqw_dev_state_t state_r;
	logic quad_r;
	logic [5:0] cnt_r;
	logic [31:0] sh_r;
	logic [31:0] sh_nxt;
	logic [5:0] step;
	logic [5:0] cnt_nxt;
	logic opc_phase;

	assign opc_phase = (state_r == SDQW_D_IDLE) || (state_r == SDQW_D_OPC);

	always_comb
	begin
		if (opc_phase)
		begin
			step = SDQW_STEP_ONE;
			sh_nxt = {sh_r[30:0], io_in[0]};
		end
		else if (quad_r)
		begin
			step = SDQW_STEP_QUAD;
			sh_nxt = {sh_r[27:0], io_in};
		end
		else
		begin
			step = SDQW_STEP_DUAL;
			sh_nxt = {sh_r[29:0], io_in[1:0]};
		end
		cnt_nxt = cnt_r + step;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			sh_r <= 32'h0000_0000;
		else if (!cs_n && sclk_rise)
			sh_r <= sh_nxt;
	end

	// ----------------------------------------------------------------
	// Command sequencing
	// ----------------------------------------------------------------
	logic [7:0] opc_now;
	logic opc_ok;
	logic opc_quad;

	assign opc_now = sh_nxt[7:0];
	assign opc_quad = (opc_now == SDQW_OPC_QUAD);
	// Multi-line writes exist only in the standard serial protocol
	assign opc_ok = !quad_serial_protocol_mode &&
		((opc_now == SDQW_OPC_DUAL) || opc_quad);

	// Target select high is the transaction reset
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || cs_n)
		begin
			state_r <= SDQW_D_IDLE;
			cnt_r <= 6'h00;
			quad_r <= 1'b0;
		end
		else if (sclk_rise)
		begin
			case (state_r)
				SDQW_D_IDLE, SDQW_D_OPC:
				begin
					if (cnt_nxt == SDQW_OPC_BITS)
					begin
						cnt_r <= 6'h00;
						quad_r <= opc_quad;
						state_r <= opc_ok ? SDQW_D_ADDR : SDQW_D_SKIP;
					end
					else
					begin
						cnt_r <= cnt_nxt;
						state_r <= SDQW_D_OPC;
					end
				end
				SDQW_D_ADDR:
				begin
					if (cnt_nxt == SDQW_ADDR_BITS)
					begin
						cnt_r <= 6'h00;
						state_r <= SDQW_D_DATA;
					end
					else
						cnt_r <= cnt_nxt;
				end
				SDQW_D_DATA:
				begin
					// Words follow back to back until target select rises
					if (cnt_nxt == SDQW_WORD_BITS)
						cnt_r <= 6'h00;
					else
						cnt_r <= cnt_nxt;
				end
				SDQW_D_SKIP:
					cnt_r <= 6'h00;
				default:
					state_r <= SDQW_D_SKIP;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Address and word commit
	// ----------------------------------------------------------------
	logic addr_done;
	logic word_done;
	logic [ADDR_W-1:0] addr_r;

	assign addr_done = !cs_n && sclk_rise && (state_r == SDQW_D_ADDR) &&
		(cnt_nxt == SDQW_ADDR_BITS);
	assign word_done = !cs_n && sclk_rise && (state_r == SDQW_D_DATA) &&
		(cnt_nxt == SDQW_WORD_BITS);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			addr_r <= '0;
		else if (addr_done)
			addr_r <= ADDR_W'(sh_nxt[15:0]);
		else if (word_done)
			addr_r <= addr_r + ADDR_W'(SDQW_ADDR_STRIDE);
	end

	// Bytes arrive low byte first, each msb first, so the word is byte-swapped
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			wr_valid <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end
		else
		begin
			wr_valid <= word_done;
			if (word_done)
			begin
				wr_addr <= addr_r;
				wr_data <= DATA_W'({sh_nxt[7:0], sh_nxt[15:8],
					sh_nxt[23:16], sh_nxt[31:24]});
			end
		end
	end

	// ----------------------------------------------------------------
	// Status pulses
	// ----------------------------------------------------------------
	logic cs_n_prev_r;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cs_n_prev_r <= 1'b1;
			cmd_reject <= 1'b0;
			word_dropped <= 1'b0;
		end
		else
		begin
			cs_n_prev_r <= cs_n;
			cmd_reject <= !cs_n && sclk_rise && opc_phase &&
				(cnt_nxt == SDQW_OPC_BITS) && !opc_ok;
			// Deselect mid-word: bits already shifted never reach the write port
			word_dropped <= cs_n && !cs_n_prev_r && (state_r == SDQW_D_DATA) &&
				(cnt_r != 6'h00);
		end
	end

	assign busy = (state_r == SDQW_D_ADDR) || (state_r == SDQW_D_DATA);

endmodule
`default_nettype wire

// file: sdqw_host.sv
// Host end: issues dual or quad address/data writes over the serial link
`timescale 1ns/100ps
`default_nettype none
module sdqw_host
	import sdqw_pkg::*;
#(
	parameter int HALF_CYC = 10, // Core cycles per serial clock half period
	parameter int WORDS_W = 8 // Width of the word count
)
(
	input wire logic core_clk, // Core clock, 125 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	sdqw_link_if.host link, // Serial link pins
	input wire logic cmd_valid, // Request to start a write
	output logic cmd_ready, // High while a request can be taken
	input wire logic cmd_quad, // 1 quad-line, 0 dual-line
	input wire logic [15:0] cmd_addr, // Start byte address
	input wire logic [WORDS_W-1:0] cmd_words, // Number of words; zero sends opcode and address only
	input wire logic data_valid, // Next word is offered
	output logic data_ready, // Word taken this cycle
	input wire logic [31:0] data_word, // Word to send
	output logic busy // Level: transaction in progress
);
	// ----------------------------------------------------------------
	// Clock divider
	// ----------------------------------------------------------------
	// Never faster than the serial clock limit, whatever the parameter says
	localparam int HALF = (HALF_CYC > SDQW_SCLK_HALF_MIN_CYC) ? HALF_CYC :
		SDQW_SCLK_HALF_MIN_CYC;
	localparam int GAP = SDQW_CS_IDLE_CYC;
	localparam int DIV_W = $clog2(((HALF > GAP) ? HALF : GAP) + 1);
	localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF - 1);
	localparam logic [DIV_W-1:0] GAP_LAST = DIV_W'(GAP - 1);

	sdqw_host_state_t state_r;
	sdqw_unit_t unit_r;
	logic [DIV_W-1:0] div_r;
	logic sclk_r;
	logic quad_r;
	logic [15:0] addr_r;
	logic [WORDS_W-1:0] words_r;
	logic [31:0] tx_r;
	logic [5:0] left_r;
	logic [5:0] step;

	always_comb
	begin
		if (unit_r == SDQW_U_OPC)
			step = SDQW_STEP_ONE;
		else if (quad_r)
			step = SDQW_STEP_QUAD;
		else
			step = SDQW_STEP_DUAL;
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_r <= SDQW_H_IDLE;
			unit_r <= SDQW_U_OPC;
			div_r <= '0;
			sclk_r <= 1'b0;
			quad_r <= 1'b0;
			addr_r <= 16'h0000;
			words_r <= '0;
			tx_r <= 32'h0000_0000;
			left_r <= 6'h00;
		end
		else
		begin
			case (state_r)
				SDQW_H_IDLE:
				begin
					div_r <= '0;
					if (cmd_valid)
					begin
						quad_r <= cmd_quad;
						addr_r <= cmd_addr;
						words_r <= cmd_words;
						unit_r <= SDQW_U_OPC;
						tx_r <= {(cmd_quad ? SDQW_OPC_QUAD : SDQW_OPC_DUAL), 24'h000000};
						left_r <= SDQW_OPC_BITS;
						state_r <= SDQW_H_SEL;
					end
				end
				SDQW_H_SEL:
				begin
					// Select low a full period (two half periods) before the first rising edge
					div_r <= div_r + DIV_W'(1);
					if (div_r == HALF_LAST)
					begin
						div_r <= '0;
						state_r <= SDQW_H_SHIFT;
					end
				end
				SDQW_H_SHIFT:
				begin
					div_r <= div_r + DIV_W'(1);
					if (div_r == HALF_LAST)
					begin
						div_r <= '0;
						sclk_r <= ~sclk_r;
						// Data changes on the falling edge, held over the rising one
						if (sclk_r)
						begin
							if (left_r > step)
							begin
								tx_r <= tx_r << step;
								left_r <= left_r - step;
							end
							else if (unit_r == SDQW_U_OPC)
							begin
								unit_r <= SDQW_U_ADDR;
								tx_r <= {addr_r, 16'h0000};
								left_r <= SDQW_ADDR_BITS;
							end
							else if (words_r == '0)
								state_r <= SDQW_H_GAP;
							else
								state_r <= SDQW_H_LOAD;
						end
					end
				end
				SDQW_H_LOAD:
				begin
					// Clock held low while the word source stalls
					div_r <= '0;
					if (data_valid)
					begin
						unit_r <= SDQW_U_DATA;
						tx_r <= {data_word[7:0], data_word[15:8],
							data_word[23:16], data_word[31:24]};
						left_r <= SDQW_WORD_BITS;
						words_r <= words_r - WORDS_W'(1);
						state_r <= SDQW_H_SHIFT;
					end
				end
				SDQW_H_GAP:
				begin
					div_r <= div_r + DIV_W'(1);
					if (div_r == GAP_LAST)
						state_r <= SDQW_H_IDLE;
				end
				default:
					state_r <= SDQW_H_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	always_comb
	begin
		link.host_io_o = 4'h0;
		link.host_io_oe = 4'h0;
		if (state_r == SDQW_H_SEL || state_r == SDQW_H_SHIFT || state_r == SDQW_H_LOAD)
		begin
			if (unit_r == SDQW_U_OPC)
			begin
				link.host_io_o = {3'h0, tx_r[31]};
				link.host_io_oe = 4'h1;
			end
			else if (quad_r)
			begin
				link.host_io_o = tx_r[31:28];
				link.host_io_oe = 4'hF;
			end
			else
			begin
				link.host_io_o = {2'h0, tx_r[31:30]};
				link.host_io_oe = 4'h3;
			end
		end
	end

	assign link.sclk = sclk_r;
	assign link.target_select_n = (state_r == SDQW_H_IDLE) || (state_r == SDQW_H_GAP);
	assign cmd_ready = (state_r == SDQW_H_IDLE);
	assign data_ready = (state_r == SDQW_H_LOAD) && data_valid;
	assign busy = !cmd_ready;

endmodule
`default_nettype wire

// file: sdqw_link_checker.sv
// Link checker: protocol relations on the serial wires between host and device ends
`timescale 1ns/100ps
`default_nettype none
module sdqw_link_checker
(
	input wire logic core_clk, // Core clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic target_select_n, // Select, active low
	input wire logic sclk, // Serial clock
	input wire logic [3:0] host_io_oe, // Host line enables
	input wire logic [3:0] dev_io_oe, // Device line enables
	input wire logic [3:0] serial_io_lines // Resolved lines
);
	logic sclk_d_r;
	logic [5:0] rise_r;
	logic [7:0] opc_r;
	logic rise;

	assign rise = sclk && !sclk_d_r;

	always_ff @(posedge core_clk)
		sclk_d_r <= sclk;

	// Counts rises per frame; saturates so long frames never wrap back into the opcode span
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || target_select_n)
			rise_r <= 6'h00;
		else if (rise && rise_r < 6'h3F)
			rise_r <= rise_r + 6'h01;
	end

	always_ff @(posedge core_clk)
	begin
		if (rise && rise_r < 6'h08)
			opc_r <= {opc_r[6:0], serial_io_lines[0]};
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_deselect;
		$rose(target_select_n);
	endsequence
	sequence s_idle_gap;
		target_select_n [*7];
	endsequence

	a_dev_quiet: assert property (dev_io_oe == 4'h0)
		else $error("device drove a link line");
	a_sclk_still: assert property (target_select_n |-> !sclk)
		else $error("serial clock high while deselected");
	a_sel_first: assert property (rise |-> !target_select_n && $past(!target_select_n))
		else $error("clock rose without prior select");
	a_opc_one_line: assert property (!target_select_n && rise_r < 6'h08 |-> host_io_oe == 4'h1)
		else $error("opcode not on line 0 alone");
	a_opc_known: assert property (!target_select_n && rise_r == 6'h08 |-> opc_r == 8'hB2 || opc_r == 8'hE2)
		else $error("unexpected opcode shifted");
	a_lane_width: assert property (rise && rise_r >= 6'h08 |-> host_io_oe == (opc_r == 8'hE2 ? 4'hF : 4'h3))
		else $error("wrong lane count after opcode");
	a_stable_high: assert property (sclk && $past(sclk) && !target_select_n |-> $stable(serial_io_lines))
		else $error("lines moved while clock high");
	a_half_min: assert property ($changed(sclk) |=> $stable(sclk) [*2])
		else $error("serial clock half period too short");
	a_cs_gap: assert property (s_deselect |-> s_idle_gap)
		else $error("select idle time too short");
endmodule
`default_nettype wire

// file: spi_dual_quad_write_decoder_tb_top.sv
// Bench: host end drives device end; a bench driver feeds a second device
`timescale 1ns/100ps
`default_nettype none
module spi_dual_quad_write_decoder_tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic qmode = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_quad = 1'b0;
	logic [15:0] cmd_addr = 16'h0000;
	logic [7:0] cmd_words = 8'h00;
	logic data_valid = 1'b1;
	logic [31:0] data_word;
	logic cmd_ready, data_ready, h_busy, wr_valid, cmd_reject, word_dropped, wr2, rej2, drop2;
	logic d_busy;
	logic [15:0] wr_addr, addr2;
	logic [31:0] wr_data, data2;
	logic [31:0] wq[8];
	logic [15:0] ea[16];
	logic [31:0] ed[16];
	logic [7:0] mon_opc;
	logic [3:0] mon_first;
	int di, ne, wi, mon_rise, mon_d0, n_rej, n_rej2, n_drop, n_drop2, n_wr2, failures, checked;
	localparam logic [15:0] A2 = 16'h01C4;
	localparam logic [31:0] W2 = 32'hC3A5_5A3C;

	sdqw_link_if lk();
	sdqw_link_if lk2();

	always #4 core_clk = ~core_clk;
	assign data_word = wq[di % 8];

	sdqw_host u_sdqw_host (.core_clk(core_clk), .sys_rst(sys_rst), .link(lk.host),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_quad(cmd_quad), .cmd_addr(cmd_addr),
		.cmd_words(cmd_words), .data_valid(data_valid), .data_ready(data_ready),
		.data_word(data_word), .busy(h_busy));
	sdqw_device u_sdqw_device (.core_clk(core_clk), .sys_rst(sys_rst), .link(lk.device),
		.quad_serial_protocol_mode(qmode), .wr_valid(wr_valid), .wr_addr(wr_addr),
		.wr_data(wr_data), .cmd_reject(cmd_reject), .word_dropped(word_dropped), .busy(d_busy));
	// Second device faces the bench driver, which can break the host's side on purpose
	sdqw_device u_sdqw_device_2 (.core_clk(core_clk), .sys_rst(sys_rst), .link(lk2.device),
		.quad_serial_protocol_mode(1'b0), .wr_valid(wr2), .wr_addr(addr2), .wr_data(data2),
		.cmd_reject(rej2), .word_dropped(drop2), .busy());
	sdqw_link_checker u_sdqw_link_checker (.core_clk(core_clk), .sys_rst(sys_rst),
		.target_select_n(lk.target_select_n), .sclk(lk.sclk), .host_io_oe(lk.host_io_oe),
		.dev_io_oe(lk.dev_io_oe), .serial_io_lines(lk.serial_io_lines));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task summarize;
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Monitors
	// ----------------------------------------
	// Select falling starts a new frame count; only this process writes the counters
	always @(posedge lk.sclk or negedge lk.target_select_n)
	begin
		if (lk.sclk !== 1'b1)
			mon_rise = 0;
		else if (lk.target_select_n === 1'b0)
		begin
			if (mon_rise < 8)
				mon_opc = {mon_opc[6:0], lk.serial_io_lines[0]};
			if (mon_rise == mon_d0)
				mon_first = lk.serial_io_lines;
			mon_rise++;
		end
	end

	always @(posedge core_clk)
		if (data_ready === 1'b1)
			di <= di + 1;

	always @(negedge core_clk)
	begin
		if (wr_valid === 1'b1)
		begin
			chk(wr_addr, ea[wi]);
			chk(wr_data, ed[wi]);
			wi++;
		end
		if (wr2 === 1'b1)
		begin
			chk(addr2, A2);
			chk(data2, W2);
		end
		n_rej += (cmd_reject === 1'b1);
		n_drop += (word_dropped === 1'b1);
		n_rej2 += (rej2 === 1'b1);
		n_drop2 += (drop2 === 1'b1);
		n_wr2 += (wr2 === 1'b1);
	end

	// ----------------------------------------
	// Host transfer and bench link driver
	// ----------------------------------------
	task send(input logic q, input logic [15:0] a, input logic [7:0] n, input logic [31:0] b);
		int t;
		logic sb;
		t = 0;
		sb = 1'b0;
		mon_d0 = q ? 12 : 16;
		for (int k = 0; k < n; k++)
		begin
			wq[(di + k) % 8] = b + 32'h0101_0101 * k;
			if (!qmode)
			begin
				ea[ne] = a + 16'(4 * k);
				ed[ne] = b + 32'h0101_0101 * k;
				ne++;
			end
		end
		cmd_quad = q;
		cmd_addr = a;
		cmd_words = n;
		cmd_valid = 1'b1;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		@(negedge core_clk);
		while (h_busy !== 1'b0 && t < 3000)
		begin
			@(negedge core_clk);
			sb |= (d_busy === 1'b1);
			t++;
		end
		repeat (20) @(negedge core_clk);
		chk(t < 3000, 32'h1);
		chk(sb, !qmode);
		chk(d_busy, 32'h0);
		chk(cmd_ready, 32'h1);
		chk(mon_opc, q ? 8'hE2 : 8'hB2);
		chk(mon_rise, (q ? 12 : 16) + n * (q ? 8 : 16));
		if (n != 0)
			chk(mon_first, q ? b[7:4] : {2'b11, b[7:6]});
		chk(wi, ne);
	endtask

	task bang(input logic [3:0] v);
		lk2.host_io_o = v;
		lk2.host_io_oe = 4'hF;
		repeat (10) @(negedge core_clk);
		lk2.sclk = 1'b1;
		repeat (10) @(negedge core_clk);
		lk2.sclk = 1'b0;
	endtask

	// Upper lines carry junk during the opcode, so only line 0 may count
	task frame2(input logic [7:0] op, input int nd);
		@(negedge core_clk);
		lk2.target_select_n = 1'b0;
		for (int i = 7; i >= 0; i--)
			bang({3'b101, op[i]});
		for (int i = 7; i >= 0; i--)
			bang({2'b00, A2[2 * i +: 2]});
		for (int i = 0; i < nd; i++)
			bang({2'b00, W2[8 * (i % 16 / 4) + 6 - 2 * (i % 4) +: 2]});
		repeat (10) @(negedge core_clk);
		lk2.target_select_n = 1'b1;
		lk2.host_io_oe = 4'h0;
		repeat (20) @(negedge core_clk);
	endtask

	initial
	begin
		lk2.target_select_n = 1'b1;
		lk2.sclk = 1'b0;
		lk2.host_io_o = 4'h0;
		lk2.host_io_oe = 4'h0;
		repeat (8) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge core_clk);
		send(1'b0, 16'h0100, 8'h01, 32'h1234_5678);
		send(1'b1, 16'hFFF8, 8'h03, 32'h8E71_C0DE);
		send(1'b0, 16'h0010, 8'h02, 32'hA0B1_C2D3);
		send(1'b1, 16'h0200, 8'h00, 32'h0000_0000);
		qmode = 1'b1;
		send(1'b0, 16'h0300, 8'h01, 32'h5555_AAAA);
		send(1'b1, 16'h0304, 8'h01, 32'h5555_AAAA);
		chk(n_rej, 32'h2);
		qmode = 1'b0;
		frame2(8'hB2, 21);
		chk(data2, W2);
		chk(addr2, A2);
		frame2(8'hA5, 4);
		chk(n_wr2, 32'h1);
		chk(n_drop2, 32'h1);
		chk(n_rej2, 32'h1);
		chk(n_drop, 32'h0);
		summarize();
	end

	// Whole run needs about 40 us; the limit leaves ample margin
	initial
	begin
		#400000;
		failures++;
		summarize();
	end
endmodule
`default_nettype wire
